// ### design/rpsel_pkg.sv
// package for the remappable pin select block: register map, field layout, reset values
// assumes a 32-bit axi4-lite slave with one aligned word per register
package rpsel_pkg;
  localparam int unsigned RPSEL_NUM_PINS = 26;
  localparam int unsigned RPSEL_SEL_W = 5;
  localparam int unsigned RPSEL_FUNC_W = 5;
  localparam logic [7:0] RPSEL_OFS_CLK_DATA = 8'h00;
  localparam logic [7:0] RPSEL_OFS_SLAVE_SEL = 8'h04;
  localparam logic [7:0] RPSEL_OFS_OUT_SEL = 8'h08;
  localparam int unsigned RPSEL_HI_LSB = 8;
  localparam int unsigned RPSEL_LO_LSB = 0;
  localparam logic [4:0] RPSEL_IN_RESET = 5'h1F;
  localparam logic [4:0] RPSEL_OUT_RESET = 5'h00;
  localparam logic [4:0] RPSEL_TIED_LOW = 5'h1F;
  localparam logic [1:0] RPSEL_RESP_OKAY = 2'h0;
  localparam logic [1:0] RPSEL_RESP_SLVERR = 2'h2;

  // software-held select fields
  typedef struct packed {
    logic [4:0] serial_clock_in_pin_sel;
    logic [4:0] serial_data_in_pin_sel;
    logic [4:0] slave_select_in_pin_sel;
    logic [4:0] pin1_output_func_sel;
    logic [4:0] pin0_output_func_sel;
  } rpsel_fields_s;

  // routed peripheral inputs
  typedef struct packed {
    logic serial_clock_input;
    logic serial_data_input;
    logic slave_select_input;
  } rpsel_spi_in_s;
endpackage

// ### design/rpsel_top.sv
// remappable pin select: spi input routing and pin 0/1 output function select
// assumes pins arrive asynchronously; axi4-lite master on aclk
`timescale 1ns/1ps
module rpsel_top
  import rpsel_pkg::*;
#(
  parameter int unsigned NUM_PINS = RPSEL_NUM_PINS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_PINS-1:0] remappable_pin_n,
  output rpsel_spi_in_s spi_in,
  output rpsel_fields_s sel_fields
);
  rpsel_fields_s fld_r, fld_nxt;
  logic [NUM_PINS-1:0] pin_meta_r, pin_sync_r;
  rpsel_spi_in_s spi_r, spi_nxt;
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic do_write;

  // pick one pin or constant low
  function automatic logic route_pin(input logic [4:0] sel, input logic [NUM_PINS-1:0] pins);
    logic res;
    res = 1'b0;
    if (sel != RPSEL_TIED_LOW && 32'(sel) < NUM_PINS) begin
      res = pins[sel];
    end
    return res;
  endfunction

  // merge a 5-bit field from a byte lane; upper bits of the lane are dropped
  function automatic logic [4:0] lane5(input logic [4:0] old, input logic en, input logic [7:0] b);
    return en ? b[4:0] : old;
  endfunction

  // register read view; unimplemented bits return zero
  function automatic logic [31:0] read_word(input logic [7:0] a, input rpsel_fields_s f);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      RPSEL_OFS_CLK_DATA: begin
        d[RPSEL_HI_LSB +: 5] = f.serial_clock_in_pin_sel;
        d[RPSEL_LO_LSB +: 5] = f.serial_data_in_pin_sel;
      end
      RPSEL_OFS_SLAVE_SEL: d[RPSEL_LO_LSB +: 5] = f.slave_select_in_pin_sel;
      RPSEL_OFS_OUT_SEL: begin
        d[RPSEL_HI_LSB +: 5] = f.pin1_output_func_sel;
        d[RPSEL_LO_LSB +: 5] = f.pin0_output_func_sel;
      end
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return a == RPSEL_OFS_CLK_DATA || a == RPSEL_OFS_SLAVE_SEL || a == RPSEL_OFS_OUT_SEL;
  endfunction

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign spi_in = spi_r;
  assign sel_fields = fld_r;

  // write channel capture, register update and write response
  always_comb begin
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] s;
    // locals start from a known value so no latch is inferred
    a = 8'h00;
    d = 32'h0000_0000;
    s = 4'h0;
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    fld_nxt = fld_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    do_write = aw_hold_nxt && w_hold_nxt && !bvalid_r;
    a = awaddr_nxt;
    d = wdata_nxt;
    s = wstrb_nxt;
    if (do_write) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = addr_ok({a[7:2], 2'b00}) ? RPSEL_RESP_OKAY : RPSEL_RESP_SLVERR;
      case ({a[7:2], 2'b00})
        RPSEL_OFS_CLK_DATA: begin
          fld_nxt.serial_clock_in_pin_sel = lane5(fld_r.serial_clock_in_pin_sel, s[1], d[15:8]);
          fld_nxt.serial_data_in_pin_sel = lane5(fld_r.serial_data_in_pin_sel, s[0], d[7:0]);
        end
        RPSEL_OFS_SLAVE_SEL:
          fld_nxt.slave_select_in_pin_sel = lane5(fld_r.slave_select_in_pin_sel, s[0], d[7:0]);
        RPSEL_OFS_OUT_SEL: begin
          fld_nxt.pin1_output_func_sel = lane5(fld_r.pin1_output_func_sel, s[1], d[15:8]);
          fld_nxt.pin0_output_func_sel = lane5(fld_r.pin0_output_func_sel, s[0], d[7:0]);
        end
        default: fld_nxt = fld_r;
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // read channel: one cycle from address taken to rvalid
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = read_word({s_axi_araddr[7:2], 2'b00}, fld_r);
      rresp_nxt = addr_ok({s_axi_araddr[7:2], 2'b00}) ? RPSEL_RESP_OKAY : RPSEL_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // routing of synchronised pins to the serial peripheral inputs
  // codes 26..30 name no pin and fall back to constant low, like the tie-off code
  always_comb begin
    spi_nxt.serial_clock_input = route_pin(fld_r.serial_clock_in_pin_sel, pin_sync_r);
    spi_nxt.serial_data_input = route_pin(fld_r.serial_data_in_pin_sel, pin_sync_r);
    spi_nxt.slave_select_input = route_pin(fld_r.slave_select_in_pin_sel, pin_sync_r);
  end

  // two-flop pin synchroniser; only the second stage feeds the routing logic
  always_ff @(posedge aclk) begin
    pin_meta_r <= remappable_pin_n;
    pin_sync_r <= pin_meta_r;
  end

  // select fields: input selects reset to the tie-off code, output selects to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fld_r.serial_clock_in_pin_sel <= RPSEL_IN_RESET;
      fld_r.serial_data_in_pin_sel <= RPSEL_IN_RESET;
      fld_r.slave_select_in_pin_sel <= RPSEL_IN_RESET;
      fld_r.pin1_output_func_sel <= RPSEL_OUT_RESET;
      fld_r.pin0_output_func_sel <= RPSEL_OUT_RESET;
    end else begin
      fld_r <= fld_nxt;
    end
  end

  // routed inputs are registered so the peripheral never sees a select-change glitch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spi_r <= '0;
    end else begin
      spi_r <= spi_nxt;
    end
  end

  // write channel holding registers and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RPSEL_RESP_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // read channel response; data holds until rready takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RPSEL_RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end
endmodule

// ### dv/rpsel_chk.sv
// checker: routing and select field relations of rpsel_top
// sees top ports only; one clock, sync active-low reset
`timescale 1ns/1ps
module rpsel_chk
  import rpsel_pkg::*;
#(
  parameter int unsigned NUM_PINS = 26
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [NUM_PINS-1:0] remappable_pin_n,
  input wire rpsel_spi_in_s spi_in,
  input wire rpsel_fields_s sel_fields
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] up_r;
  // three clean edges, so the pin pipe holds real levels
  always_ff @(posedge aclk) up_r <= {up_r[1:0], aresetn};
  // level a code picks; codes past the last pin give low
  function automatic logic pick(logic [NUM_PINS-1:0] p, logic [4:0] s);
    return (s < NUM_PINS) ? p[s] : 1'b0;
  endfunction
  sequence s_up;
    &up_r;
  endsequence
  property p_clk;
    s_up |-> spi_in[2] == pick($past(remappable_pin_n, 3), $past(sel_fields[24:20]));
  endproperty
  property p_dat;
    s_up |-> spi_in[1] == pick($past(remappable_pin_n, 3), $past(sel_fields[19:15]));
  endproperty
  property p_ss;
    s_up |-> spi_in[0] == pick($past(remappable_pin_n, 3), $past(sel_fields[14:10]));
  endproperty
  property p_rsv;
    s_axi_rvalid |-> (s_axi_rdata & 32'hFFFFE0E0) == 32'h0;
  endproperty
  property p_p1;
    $past(aresetn) && $changed(sel_fields[9:5]) |-> sel_fields[9:5] == $past(s_axi_wdata[12:8]);
  endproperty
  property p_p0;
    $past(aresetn) && $changed(sel_fields[4:0]) |-> sel_fields[4:0] == $past(s_axi_wdata[4:0]);
  endproperty
  property p_rst;
    !$past(aresetn) |-> sel_fields == 25'h1FFFC00;
  endproperty
  a_clk: assert property (p_clk) else $error("clock input misrouted");
  a_dat: assert property (p_dat) else $error("data input misrouted");
  a_ss: assert property (p_ss) else $error("select input misrouted");
  a_rsv: assert property (p_rsv) else $error("unused bits read high");
  a_p1: assert property (p_p1) else $error("pin1 function wrong");
  a_p0: assert property (p_p0) else $error("pin0 function wrong");
  a_rst: assert property (p_rst) else $error("reset fields wrong");
endmodule
bind rpsel_top rpsel_chk #(.NUM_PINS(NUM_PINS)) chk (.aclk, .aresetn, .s_axi_wdata, .s_axi_rdata,
  .s_axi_rvalid, .remappable_pin_n, .spi_in, .sel_fields);

// ### dv/rpsel_pins.sv
// remappable pin model: pad levels as the bench asks
// pads move just after a rising edge, unrelated to the selects
`timescale 1ns/1ps
module rpsel_pins
  import rpsel_pkg::*;
(
  input wire logic aclk,
  input wire logic [RPSEL_NUM_PINS-1:0] want,
  output logic [RPSEL_NUM_PINS-1:0] pins
);
  // pads follow the request one edge later
  always_ff @(posedge aclk) pins <= want;
endmodule

// ### dv/rpsel_top_tb.sv
// bench for rpsel_top: axi4-lite accesses and spi input routing
// pins come from rpsel_pins; checker is bound separately
`timescale 1ns/1ps
module rpsel_top_tb
  import rpsel_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [25:0] want, remappable_pin_n;
  rpsel_spi_in_s spi_in;
  rpsel_fields_s sel_fields;
  int err_total, checked;
  rpsel_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .remappable_pin_n, .spi_in,
    .sel_fields);
  rpsel_pins pads (.aclk, .want, .pins(remappable_pin_n));
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  // one write (w=1) or read; read data compared against d
  task automatic xf(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    logic ta, tw, v;
    logic [31:0] g;
    logic [1:0] r;
    ta = 0;
    tw = !w;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
    do begin
      @(negedge aclk);
      ta |= w ? s_axi_awready : s_axi_arready;
      tw |= s_axi_wready;
      @(posedge aclk);
      if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
      if (tw) s_axi_wvalid <= 0;
    end while (!(ta && tw));
    {s_axi_bready, s_axi_rready} <= {w, !w};
    do begin
      @(negedge aclk);
      v = w ? s_axi_bvalid : s_axi_rvalid;
      g = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
    end while (!v);
    {s_axi_bready, s_axi_rready} <= 2'b00;
    ck(32'(r), 32'(er));
    if (!w) ck(g, d);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // 200 MHz clock
  initial begin
    aclk = 0;
    forever #2.5 aclk = ~aclk;
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    report_and_stop;
  end
  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {err_total, checked} = 0;
    want = 26'h3FFFFFF;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    @(negedge aclk);
    ck(32'(spi_in), 32'h0);
    @(posedge aclk);
    for (int i = 0; i < 3; i++) begin
      xf(0, 8'(4 * i), i == 1 ? 32'h1F : i == 0 ? 32'h1F1F : 32'h0, 4'h0, 2'h0);
      xf(1, 8'(4 * i), 32'hFFFFFFFF, 4'hF, 2'h0);
      xf(0, 8'(4 * i), i == 1 ? 32'h1F : 32'h1F1F, 4'h0, 2'h0);
    end
    xf(1, 8'h08, 32'h0A15, 4'h1, 2'h0);
    ck(32'(sel_fields[9:0]), 32'h3F5);
    xf(1, 8'h08, 32'h0A15, 4'h2, 2'h0);
    ck(32'(sel_fields[9:0]), 32'h155);
    $display("test regs done");
    for (int n = 0; n < 26; n++) begin
      // even n: clock and slave select on pin n; odd n: data on pin n, the others on a low pin
      want <= 26'h1 << n;
      xf(1, 8'h00, n % 2 ? {19'h0, 5'(25 - n), 3'h0, 5'(n)} :
        {19'h0, 5'(n), 3'h0, 5'(25 - n)}, 4'h3, 2'h0);
      xf(1, 8'h04, 32'(n % 2 ? 25 - n : n), 4'h1, 2'h0);
      repeat (4) @(negedge aclk);
      ck(32'(spi_in), n % 2 ? 32'h2 : 32'h5);
      @(posedge aclk);
    end
    $display("test route done");
    want <= 26'h3FFFFFF;
    xf(1, 8'h00, 32'h1F1F, 4'h3, 2'h0);
    xf(1, 8'h04, 32'h1F, 4'h1, 2'h0);
    repeat (4) @(negedge aclk);
    ck(32'(spi_in), 32'h0);
    @(posedge aclk);
    // a code past the last pin also gives a low input
    xf(1, 8'h04, 32'h1A, 4'h1, 2'h0);
    repeat (4) @(negedge aclk);
    ck(32'(spi_in), 32'h0);
    @(posedge aclk);
    xf(1, 8'h0C, 32'h1, 4'hF, 2'h2);
    xf(0, 8'h0C, 32'h0, 4'h0, 2'h2);
    $display("test tie and unmapped done");
    report_and_stop;
  end
endmodule
